/* logic/exec_params.svh */
/*
 * Constants for the OR-immediate and stack-pop execution block:
 * widths, opcode patterns and sub-codes, stack steps.
 * Assumes inclusion by bare name from design files.
 */
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

`define ACC_W 40
`define WORD_W 16
`define ADDR_W 16
`define UPPER_SHIFT 5'h10
`define OP_OR_UPPER 8'h7A
`define OP_OR_SHIFT 8'h73
`define OP_OR_MEM 8'hF5
`define OP_POP_PAIR 7'h1D
`define OP_POP_ONE 7'h28
`define SUB_POP_ONE 3'h2
`define SUB_POP_DBL 3'h3
`define OP_POP_REGMEM 8'hE4
`define SP_STEP_ONE 16'h0001
`define SP_STEP_TWO 16'h0002
`define SP_RESET 16'h0000
`define NUM_REGS 16
`define ACC_COUNT 4

`endif

/* logic/exec_pkg.sv */
/*
 * Types shared by the execution block: operation kinds, decoded
 * instruction, memory request and machine state.
 * Assumes exec_params.svh is on the include path.
 */
package exec_pkg;
  `include "exec_params.svh"

  typedef enum logic [3:0] {
    op_none, op_or_upper, op_or_shift, op_or_mem,
    op_pop_pair, op_pop_one, op_pop_regmem, op_pop_dbl, op_illegal
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [3:0] first_register_field;
    logic [3:0] second_register_field;
    logic [1:0] source_accumulator;
    logic [1:0] destination_accumulator;
    logic [3:0] four_bit_shift_amount;
    logic [15:0] unsigned_immediate_word;
  } decoded_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef enum logic [2:0] {
    st_idle, st_read_a, st_read_b, st_write, st_done
  } exec_state_t;
endpackage

/* logic/exec_decoder.sv */
/*
 * Combinational decoder: turns a 32-bit instruction (left justified)
 * into a decoded_t record.
 * Assumes the front end presents the instruction with its opcode byte in
 * bits 31:24 and a repeat flag from the repeat controller.
 */
`timescale 1ns/1ps
module exec_decoder
  import exec_pkg::*;
(
  // instruction in
  input wire logic [31:0] instr,
  input wire logic in_single_repeat,
  // decoded out
  output decoded_t dec
);
  always_comb begin
    dec = '0;
    dec.kind = op_none;
    if (instr[31:24] == `OP_OR_UPPER && instr[3:1] == 3'h3) begin
      dec.kind = op_or_upper;
      dec.unsigned_immediate_word = instr[23:8];
      dec.source_accumulator = instr[7:6];
      dec.destination_accumulator = instr[5:4];
    end else if (instr[31:24] == `OP_OR_SHIFT) begin
      dec.kind = op_or_shift;
      dec.unsigned_immediate_word = instr[23:8];
      dec.source_accumulator = instr[7:6];
      dec.destination_accumulator = instr[5:4];
      dec.four_bit_shift_amount = instr[3:0];
    end else if (instr[31:24] == `OP_OR_MEM) begin
      dec.kind = op_or_mem;
      dec.unsigned_immediate_word = instr[15:0];
    end else if (instr[31:25] == `OP_POP_PAIR) begin
      dec.kind = op_pop_pair;
      dec.first_register_field = instr[23:20];
      dec.second_register_field = instr[19:16];
    end else if (instr[31:25] == `OP_POP_ONE && instr[18:16] == `SUB_POP_ONE) begin
      dec.kind = in_single_repeat ? op_illegal : op_pop_one;
      dec.first_register_field = instr[23:20];
    end else if (instr[31:25] == `OP_POP_ONE && instr[18:16] == `SUB_POP_DBL) begin
      dec.kind = in_single_repeat ? op_illegal : op_pop_dbl;
      dec.destination_accumulator = instr[21:20];
    end else if (instr[31:24] == `OP_POP_REGMEM && instr[10] == 1'b1) begin
      // three-byte form: destination and marker bit sit in the third byte
      dec.kind = op_pop_regmem;
      dec.first_register_field = instr[15:12];
    end else if (instr[31:24] != 8'h00) begin
      dec.kind = op_illegal;
    end
  end
endmodule

/* logic/exec_stack_agen.sv */
/*
 * Stack address generator: owns the data stack pointer and steps it.
 * Assumes the sequencer requests at most one step per cycle.
 */
`timescale 1ns/1ps
module exec_stack_agen
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // step request
  input wire logic step_one,
  input wire logic step_two,
  // pointer
  output logic [15:0] data_stack_pointer
);
  logic [15:0] sp;
  logic [15:0] next_sp;

  always_comb begin
    next_sp = sp;
    if (step_two) begin
      next_sp = sp + `SP_STEP_TWO;
    end else if (step_one) begin
      next_sp = sp + `SP_STEP_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= `SP_RESET;
    end else begin
      sp <= next_sp;
    end
  end

  assign data_stack_pointer = sp;
endmodule

/* logic/or_immediate_and_stack_pop_exec.sv */
/*
 * Execution datapath for the OR-immediate forms and the stack pop family.
 * Holds four 40-bit accumulators and twelve 16-bit registers, sequences
 * data memory reads and writes through a single-cycle word port.
 * Assumes memory answers a read in the cycle mem_req.rd stands, and that the memory
 * operand address of read-modify-write forms arrives with the instruction.
 */
// How it works
// - upper-immediate OR: destination = source OR (immediate << 16).
// - upper-immediate OR is 40 bits wide, immediate zero-extended.
// - shifted OR: source OR (immediate << 4-bit amount) into destination.
// - shift and OR finish together in one cycle.
// - both mode bits clear: use source bits 31-0 zero-extended; else 39-0.
// - carry flag untouched by the shifted OR.
// - memory OR: read word, OR immediate over 16 bits, write back.
// - single-word pops into accumulators keep bits 39-16.
// - stack pointer increments happen in the dedicated stack generator.
// - pair pop: SP word to first, SP+1 word to second, SP += 2.
// - pair pop decoded from 0011 101E with the two register fields.
// - a popped word into an accumulator lands in bits 15-0.
// - single pop: SP word to destination, SP += 1.
// - register-memory pop: SP to register, SP+1 to memory, SP += 2.
// - double pop: SP word to bits 31-16, next to 15-0, guards kept.
// - single and double pops refused under single-instruction repeat.
`timescale 1ns/1ps
module or_immediate_and_stack_pop_exec
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction issue
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic source_given,
  input wire logic [15:0] operand_addr,
  input wire logic in_single_repeat,
  // mode bits
  input wire logic wide_overflow_mode_bit,
  input wire logic legacy_compat_mode_bit,
  // data memory
  output mem_req_t mem_req,
  input wire logic [15:0] mem_rdata,
  // status
  output logic busy,
  output logic done,
  output logic illegal,
  output logic carry,
  output logic [15:0] data_stack_pointer,
  output logic [39:0] acc_view [`ACC_COUNT]
);
  typedef struct packed {
    exec_state_t state;
    decoded_t op;
    logic [15:0] addr;
    logic [15:0] word_a;
    logic busy;
    logic done;
    logic illegal;
    logic carry;
    mem_req_t req;
  } state_t;

  state_t s;
  state_t next_s;
  logic rst_meta;
  logic rst_sync_n;
  decoded_t dec;
  logic [39:0] acc [`ACC_COUNT];
  logic [15:0] regs [`ACC_COUNT:`NUM_REGS-1];
  logic step_one;
  logic step_two;
  logic [15:0] sp;
  logic wr_acc;
  logic [1:0] wr_acc_idx;
  logic [39:0] wr_acc_val;
  logic wr_reg;
  logic [3:0] wr_reg_idx;
  logic [15:0] wr_reg_val;
  logic wr_reg2;
  logic [3:0] wr_reg2_idx;
  logic [15:0] wr_reg2_val;

  // register file codes 0-3 are accumulators, the rest 16-bit registers
  function automatic logic is_acc(input logic [3:0] code);
    is_acc = (code[3:2] == 2'b00);
  endfunction

  // operand selection shared by both immediate OR forms
  function automatic logic [39:0] src_acc(input decoded_t d, input logic given,
                                          input logic narrow);
    logic [1:0] idx;
    logic [39:0] v;
    idx = given ? d.source_accumulator : d.destination_accumulator;
    v = acc[idx];
    src_acc = narrow ? {8'h00, v[31:0]} : v;
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  exec_decoder u_dec (
    .instr(instr),
    .in_single_repeat(in_single_repeat),
    .dec(dec)
  );

  exec_stack_agen u_sp (
    .clk(clk),
    .rst_n(rst_sync_n),
    .step_one(step_one),
    .step_two(step_two),
    .data_stack_pointer(sp)
  );

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.illegal = 1'b0;
    next_s.req = '0;
    step_one = 1'b0;
    step_two = 1'b0;
    wr_acc = 1'b0;
    wr_acc_idx = 2'h0;
    wr_acc_val = '0;
    wr_reg = 1'b0;
    wr_reg_idx = 4'h0;
    wr_reg_val = '0;
    wr_reg2 = 1'b0;
    wr_reg2_idx = 4'h0;
    wr_reg2_val = '0;
    unique case (s.state)
      st_idle: begin
        if (issue) begin
          next_s.op = dec;
          next_s.addr = operand_addr;
          unique case (dec.kind)
            op_or_upper: begin
              wr_acc = 1'b1;
              wr_acc_idx = dec.destination_accumulator;
              // full 40-bit operand, immediate zero-extended
              wr_acc_val = src_acc(dec, source_given, 1'b0)
                           | ({24'h000000, dec.unsigned_immediate_word} << `UPPER_SHIFT);
              next_s.done = 1'b1;
            end
            op_or_shift: begin
              wr_acc = 1'b1;
              wr_acc_idx = dec.destination_accumulator;
              // single cycle, carry left alone
              wr_acc_val = src_acc(dec, source_given,
                                   !wide_overflow_mode_bit && !legacy_compat_mode_bit)
                           | ({24'h000000, dec.unsigned_immediate_word}
                              << dec.four_bit_shift_amount);
              next_s.done = 1'b1;
            end
            op_or_mem: begin
              next_s.req.rd = 1'b1;
              next_s.req.addr = operand_addr;
              next_s.state = st_read_a;
            end
            op_pop_pair, op_pop_one, op_pop_regmem, op_pop_dbl: begin
              next_s.req.rd = 1'b1;
              next_s.req.addr = sp;
              next_s.state = st_read_a;
            end
            op_illegal: begin
              next_s.illegal = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      st_read_a: begin
        // read answered in this cycle, so the word is taken here
        next_s.word_a = mem_rdata;
        unique case (s.op.kind)
          op_or_mem: begin
            next_s.req.wr = 1'b1;
            next_s.req.addr = s.addr;
            next_s.req.wdata = mem_rdata | s.op.unsigned_immediate_word;
            next_s.state = st_write;
          end
          op_pop_one: begin
            wr_reg = 1'b1;
            wr_reg_idx = s.op.first_register_field;
            wr_reg_val = mem_rdata;
            step_one = 1'b1;
            next_s.done = 1'b1;
            next_s.state = st_idle;
          end
          default: begin
            next_s.req.rd = 1'b1;
            next_s.req.addr = sp + `SP_STEP_ONE;
            next_s.state = st_read_b;
          end
        endcase
      end
      st_read_b: begin
        step_two = 1'b1;
        next_s.done = 1'b1;
        next_s.state = st_idle;
        unique case (s.op.kind)
          op_pop_pair: begin
            wr_reg = 1'b1;
            wr_reg_idx = s.op.first_register_field;
            wr_reg_val = s.word_a;
            wr_reg2 = 1'b1;
            wr_reg2_idx = s.op.second_register_field;
            wr_reg2_val = mem_rdata;
          end
          op_pop_regmem: begin
            wr_reg = 1'b1;
            wr_reg_idx = s.op.first_register_field;
            wr_reg_val = s.word_a;
            next_s.req.wr = 1'b1;
            next_s.req.addr = s.addr;
            next_s.req.wdata = mem_rdata;
          end
          default: begin
            wr_acc = 1'b1;
            wr_acc_idx = s.op.destination_accumulator;
            wr_acc_val = {acc[s.op.destination_accumulator][39:32], s.word_a, mem_rdata};
          end
        endcase
      end
      st_write: begin
        // write stands this cycle; memory takes it at the closing edge
        next_s.done = 1'b1;
        next_s.state = st_idle;
      end
      st_done: begin
        next_s.state = st_idle;
      end
    endcase
    next_s.busy = (next_s.state != st_idle);
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // register file writes; pair pop may hit two targets, second wins on a clash
  genvar g;
  generate
    for (g = 0; g < `NUM_REGS; g++) begin : g_regs
      if (g < `ACC_COUNT) begin : g_acc
        always_ff @(posedge clk or negedge rst_sync_n) begin
          if (!rst_sync_n) begin
            acc[g] <= '0;
            acc_view[g] <= '0;
          end else begin
            if (wr_acc && wr_acc_idx == 2'(g)) begin
              acc[g] <= wr_acc_val;
            end else if (wr_reg2 && is_acc(wr_reg2_idx) && wr_reg2_idx[1:0] == 2'(g)) begin
              acc[g] <= {acc[g][39:16], wr_reg2_val};
            end else if (wr_reg && is_acc(wr_reg_idx) && wr_reg_idx[1:0] == 2'(g)) begin
              acc[g] <= {acc[g][39:16], wr_reg_val};
            end
            acc_view[g] <= acc[g];
          end
        end
      end else begin : g_plain
        // plain registers are not visible at the ports
        always_ff @(posedge clk or negedge rst_sync_n) begin
          if (!rst_sync_n) begin
            regs[g] <= '0;
          end else if (wr_reg2 && wr_reg2_idx == 4'(g)) begin
            regs[g] <= wr_reg2_val;
          end else if (wr_reg && wr_reg_idx == 4'(g)) begin
            regs[g] <= wr_reg_val;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_stack_pointer <= `SP_RESET;
    end else begin
      data_stack_pointer <= sp;
    end
  end

  assign mem_req = s.req;
  assign busy = s.busy;
  assign done = s.done;
  assign illegal = s.illegal;
  assign carry = s.carry;
endmodule

/* test/exec_props.sv */
/* Port checker for the OR-immediate and stack-pop block.
   Assumes it is bound onto the top module. */
`timescale 1ns/1ps
`include "exec_params.svh"
module exec_props
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // issue side
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [15:0] operand_addr,
  input wire logic in_single_repeat,
  // results
  input wire mem_req_t mem_req,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic carry
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take;
  logic pop1;
  assign take = issue && !busy;
  // single and double pops share one opcode, told apart by bit 16
  assign pop1 = instr[31:25] == `OP_POP_ONE && instr[18:17] == 2'b01;

  carry_held_low_a: assert property (carry == 1'b0)
    else $error("carry moved");
  rd_wr_apart_a: assert property (!(mem_req.rd && mem_req.wr))
    else $error("read and write together");
  repeat_refused_a: assert property (
    take && in_single_repeat && pop1 |=> illegal && !done)
    else $error("pop under single repeat not refused");
  refused_quiet_a: assert property (
    take && in_single_repeat && pop1 |=> !mem_req.rd && !mem_req.wr)
    else $error("refused pop touched memory");
  upper_one_cycle_a: assert property (
    take && instr[31:24] == `OP_OR_UPPER |=> done && !mem_req.rd)
    else $error("upper OR not one cycle");
  shift_one_cycle_a: assert property (
    take && instr[31:24] == `OP_OR_SHIFT |=> done && !mem_req.rd)
    else $error("shifted OR not one cycle");
  pair_two_reads_a: assert property (
    take && instr[31:25] == `OP_POP_PAIR |=> mem_req.rd ##1
    mem_req.rd && mem_req.addr == $past(mem_req.addr) + 16'h0001 ##1 done)
    else $error("pair pop reads wrong");
  single_read_a: assert property (
    take && pop1 && !instr[16] && !in_single_repeat |=> mem_req.rd ##1 done)
    else $error("single pop sequence wrong");
  dbl_two_reads_a: assert property (
    take && pop1 && instr[16] && !in_single_repeat |=> mem_req.rd ##1 mem_req.rd ##1 done)
    else $error("double pop sequence wrong");
  ormem_rmw_a: assert property (
    take && instr[31:24] == `OP_OR_MEM |=> mem_req.rd &&
    mem_req.addr == $past(operand_addr) ##1 mem_req.wr && mem_req.addr == $past(operand_addr, 2)
    ##1 done)
    else $error("memory OR sequence wrong");
  regmem_copy_a: assert property (
    take && instr[31:24] == `OP_POP_REGMEM && instr[10] |=> mem_req.rd ##1 mem_req.rd ##1
    done && mem_req.wr && mem_req.addr == $past(operand_addr, 3))
    else $error("register-memory pop sequence wrong");

  cover property (take && instr[31:25] == `OP_POP_PAIR);
  cover property (illegal);
  cover property (mem_req.wr);
  cover property (take && instr[31:24] == `OP_POP_REGMEM && instr[10]);
endmodule

/* test/stack_mem.sv */
/* Behavioural data memory behind the block, read answered in its own cycle.
   Assumes requests come as one-cycle pulses; 256 words are modelled. */
`timescale 1ns/1ps
module stack_mem
  import exec_pkg::*;
(
  // clock
  input wire logic clk,
  // port
  input wire mem_req_t mem_req,
  output logic [15:0] mem_rdata
);
  logic [15:0] words [256];
  // inverse shown with no read so a stale word never passes for data
  assign mem_rdata = mem_req.rd ? words[mem_req.addr[7:0]] : ~words[mem_req.addr[7:0]];
  always @(posedge clk) begin
    if (mem_req.wr)
      words[mem_req.addr[7:0]] <= mem_req.wdata;
  end
endmodule

/* test/or_immediate_and_stack_pop_exec_test.sv */
/* Self-checking bench for the OR-immediate and stack-pop block.
   Assumes the memory model and checker compile alongside. */
`timescale 1ns/1ps
`include "exec_params.svh"
module or_immediate_and_stack_pop_exec_test
  import exec_pkg::*;
();
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic issue = 1'b0;
  logic [31:0] instr = 32'h0;
  logic source_given = 1'b0;
  logic [15:0] operand_addr = 16'h0;
  logic in_single_repeat = 1'b0;
  logic wide_overflow_mode_bit = 1'b0;
  logic legacy_compat_mode_bit = 1'b0;
  mem_req_t mem_req;
  logic [15:0] mem_rdata;
  logic busy, done, illegal, carry;
  logic [15:0] data_stack_pointer;
  logic [39:0] acc_view [`ACC_COUNT];
  logic [39:0] e [4];
  logic [15:0] sp = 16'h0;
  logic bad;
  int error_cnt = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  or_immediate_and_stack_pop_exec or_immediate_and_stack_pop_exec_inst (.clk(clk), .rstn(rstn),
    .issue(issue), .instr(instr), .source_given(source_given), .operand_addr(operand_addr),
    .in_single_repeat(in_single_repeat), .wide_overflow_mode_bit(wide_overflow_mode_bit),
    .legacy_compat_mode_bit(legacy_compat_mode_bit), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .busy(busy), .done(done), .illegal(illegal), .carry(carry),
    .data_stack_pointer(data_stack_pointer), .acc_view(acc_view));
  stack_mem stack_mem_inst (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  task automatic chk(input string what, input logic [39:0] want, input logic [39:0] got);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, got);
    end
  endtask

  // one instruction, held for the taking edge, then wait for its answer
  task automatic run(input logic [31:0] op, input logic rep, input logic sg,
                     input logic [15:0] a);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    issue = 1'b1;
    instr = op;
    in_single_repeat = rep;
    source_given = sg;
    operand_addr = a;
    @(posedge clk);
    #1;
    issue = 1'b0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 10)
      chk("answer", 1, 0);
    bad = (illegal === 1'b1);
  endtask

  // outputs lag a cycle, so let two edges pass before looking
  task automatic state(input string name);
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++)
      chk($sformatf("acc%0d", i), e[i], acc_view[i]);
    chk("sp", {24'h0, sp}, {24'h0, data_stack_pointer});
    chk("carry", 0, {39'h0, carry});
    $display("test %s finished", name);
  endtask

  task automatic t_pair;
    run({7'h1D, 1'b0, 4'h0, 4'h1, 16'h0}, 0, 1, 0);
    e[0] = 40'h4890;
    e[1] = 40'h2300;
    sp = 16'h0002;
    state("pop_pair");
  endtask

  task automatic t_refuse;
    run({7'h28, 1'b0, 4'h2, 1'b0, 3'h3, 16'h0}, 1, 1, 0);
    chk("illegal_dbl", 1, bad);
    run({7'h28, 1'b0, 4'h3, 1'b0, 3'h2, 16'h0}, 1, 1, 0);
    chk("illegal_one", 1, bad);
    state("refused");
  endtask

  task automatic t_pops;
    run({7'h28, 1'b0, 4'h2, 1'b0, 3'h3, 16'h0}, 0, 1, 0);
    e[2] = 40'h5644F800;
    sp = 16'h0004;
    run({7'h28, 1'b0, 4'h3, 1'b0, 3'h2, 16'h0}, 0, 1, 0);
    e[3] = 40'h1234;
    sp = 16'h0005;
    state("pop_dbl_one");
  endtask

  task automatic t_or_imm;
    run({8'h7A, 16'hFFFF, 2'd0, 2'd1, 4'h6}, 0, 1, 0);
    e[1] = e[0] | 40'hFFFF0000;
    run({8'h7A, 16'h00F0, 2'd2, 2'd3, 4'h6}, 1, 0, 0);
    e[3] = e[3] | 40'h00F00000;
    wide_overflow_mode_bit = 1'b1;
    run({8'h73, 16'h8001, 2'd1, 2'd2, 4'hF}, 0, 1, 0);
    e[2] = e[1] | (40'h8001 << 15);
    wide_overflow_mode_bit = 1'b0;
    run({8'h73, 16'h0FC0, 2'd3, 2'd0, 4'h4}, 0, 1, 0);
    e[0] = e[3] | (40'h0FC0 << 4);
    state("or_immediate");
  endtask

  task automatic t_mem;
    run({8'hE4, 8'h00, 4'h1, 4'h4, 8'h00}, 0, 1, 16'h0080);
    e[1] = {e[1][39:16], 16'hA5A5};
    sp = 16'h0007;
    state("pop_reg_mem");
    chk("word80", 40'h6903, {24'h0, stack_mem_inst.words[8'h80]});
    run({8'hF5, 8'h00, 16'h0FC0}, 0, 1, 16'h0080);
    state("or_memory");
    chk("word80", 40'h6FC3, {24'h0, stack_mem_inst.words[8'h80]});
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 4; i++)
      e[i] = 40'h0;
    stack_mem_inst.words[0] = 16'h4890;
    stack_mem_inst.words[1] = 16'h2300;
    stack_mem_inst.words[2] = 16'h5644;
    stack_mem_inst.words[3] = 16'hF800;
    stack_mem_inst.words[4] = 16'h1234;
    stack_mem_inst.words[5] = 16'hA5A5;
    stack_mem_inst.words[6] = 16'h6903;
    stack_mem_inst.words[8'h80] = 16'h5678;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    t_pair();
    t_refuse();
    t_pops();
    t_or_imm();
    t_mem();
    conclude();
  end

  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
endmodule

bind or_immediate_and_stack_pop_exec exec_props exec_props_inst (.clk(clk), .rstn(rstn),
  .issue(issue), .instr(instr), .operand_addr(operand_addr),
  .in_single_repeat(in_single_repeat), .mem_req(mem_req), .busy(busy), .done(done),
  .illegal(illegal), .carry(carry));
